//--- viu_defs.svh
// Purpose: Offsets, field positions, reset values and vectors of the
//          vectored priority interrupt unit.
// Assumes: Included by bare name from the core.
// Notes:   Definitions only.
`ifndef VIU_DEFS_SVH
`define VIU_DEFS_SVH

// ==========================================================
// Register addresses on the 8-bit I/O port
`define VIU_ADDR_MASK      8'hbb
`define VIU_ADDR_STATUS    8'hb0
`define VIU_ADDR_CLEAR     8'hb1
`define VIU_ADDR_ENABLE    8'hb2
`define VIU_ADDR_MODE      8'hb3

// ==========================================================
// Mask bit positions
`define VIU_MASK_RST_A     3
`define VIU_MASK_RST_B     2
`define VIU_MASK_RST_C     1
`define VIU_MASK_GENERAL   0

// ==========================================================
// Event status bit positions (status, clear, enable)
`define VIU_EVT_NMI        0
`define VIU_EVT_RST_A      1
`define VIU_EVT_RST_B      2
`define VIU_EVT_RST_C      3
`define VIU_EVT_GENERAL    4

// ==========================================================
// Restart addresses, reset values and highest legal mode
`define VIU_VEC_NMI        16'h0066
`define VIU_VEC_RST_A      16'h003c
`define VIU_VEC_RST_B      16'h0034
`define VIU_VEC_RST_C      16'h002c
`define VIU_RESET_MODE     2'h0
`define VIU_MODE_MAX       2'h2

`endif

//--- viu_pkg.sv
// Purpose: Types shared by the interrupt unit and its bench.
// Assumes: Nothing beyond the defs header.
// Notes:   Source codes name which request was served.
`default_nettype none

package viu_pkg;

   // =======================================================
   // Served request source
   typedef enum logic [2:0]
   {
      SRC_NONE,
      SRC_NMI,
      SRC_RST_A,
      SRC_RST_B,
      SRC_RST_C,
      SRC_GENERAL
   } viu_src_e;

   // General request response mode, 0 to 2
   typedef logic [1:0] viu_mode_t;

endpackage

`default_nettype wire

//--- viu_core.sv
// Purpose: Vectored priority interrupt unit of an 8-bit processor.
// Assumes: Requests and sequencer strobes are synchronous to sys_clk.
//          Sequencer strobes are one-cycle pulses.
// Notes:   One request served per instruction boundary.
//          NMI is edge latched; restarts and general are levels.
//          Any acceptance, NMI included, clears the master enable.
//          The mask is write-only; its address reads back zero.
//
// Behaviour
// [R1] NMI restarts execution at 0x66
// [R2] NMI ignores mask and master enable
// [R3] Restart inputs vector to 3C, 34, 2C
// [R4] Priority NMI, first, second, third, general
// [R5] General request has modes 0, 1, 2
// [R6] Reset selects general request mode 0
// [R7] Acknowledge driven on dedicated output
// [R8] I/O address BB reserved for mask
// [R9] Mask bits 3..0 enable restarts, general
// [R10] Maskable needs mask bit and master enable
// [R11] Mask register is write-only
// [R12] Resolve and accept one per boundary
`default_nettype none
`include "viu_defs.svh"

module viu_core
#(
   parameter int          ADDR_W        = 8,
   parameter logic [15:0] MODE1_VECTOR  = 16'h0038
)
(
   input  wire logic               sys_clk,
   input  wire logic               rst,
   // Request inputs, active high levels
   input  wire logic               nmiRequest,
   input  wire logic               restartRequestFirst,
   input  wire logic               restartRequestSecond,
   input  wire logic               restartRequestThird,
   input  wire logic               generalRequest,
   // Sequencer strobes, one-cycle pulses
   input  wire logic               instrBoundary,
   input  wire logic               enableInterruptsInstruction,
   input  wire logic               disableInterruptsInstruction,
   input  wire logic               modeLoad,
   input  wire viu_pkg::viu_mode_t modeValue,
   // I/O register port
   input  wire logic [ADDR_W-1:0]  regAddr,
   input  wire logic [7:0]         regWrData,
   input  wire logic               regWrStb,
   input  wire logic               regRdStb,
   output var  logic [7:0]         regRdData,
   // Sequencer answers
   output var  logic               takeInterrupt,
   output var  logic [15:0]        vectorAddr,
   output var  viu_pkg::viu_src_e  servedSource,
   output var  viu_pkg::viu_mode_t generalMode,
   output var  logic               requestAcknowledgeOut,
   output var  logic               irqOut
);
   import viu_pkg::*;

   // =======================================================
   // Elaboration check
   // The decode below compares against 8-bit I/O offsets, so
   // any other address width would alias or miss registers
   if (ADDR_W != 8)
   begin : g_addr_w_check
      $error("viu_core: I/O address must be 8 bits");
   end

   // =======================================================
   // Vector lookup for a served source
   function automatic logic [15:0] vecOf(input viu_src_e s,
                                         input viu_mode_t m);
      logic [15:0] v;
      v = 16'h0000;
      // Modes 0 and 2 return zero: the sequencer then takes the
      // instruction or table pointer from the bus itself
      unique case (s)
         SRC_NMI:     v = `VIU_VEC_NMI;     // [R1]
         SRC_RST_A:   v = `VIU_VEC_RST_A;   // [R3]
         SRC_RST_B:   v = `VIU_VEC_RST_B;   // [R3]
         SRC_RST_C:   v = `VIU_VEC_RST_C;   // [R3]
         SRC_GENERAL: v = (m == 2'h1) ? MODE1_VECTOR : 16'h0000; // [R5]
         SRC_NONE:    v = 16'h0000;
      endcase
      return v;
   endfunction

   // =======================================================
   // State
   // Architectural state, cleared by rst
   logic [3:0]  maskReg;          // Per-input enables, write-only
   logic        masterEnable;     // Set by enable instruction
   viu_mode_t   modeReg;          // General request mode
   logic        nmiPrev;          // Last NMI level
   logic        nmiPending;       // Latched NMI edge
   logic [4:0]  statusReg;        // Sticky served events
   logic [4:0]  irqEnable;        // Event enables

   // Next values of the state and of the registered outputs
   logic [3:0]  next_maskReg;
   logic        next_masterEnable;
   viu_mode_t   next_modeReg;
   logic        next_nmiPrev;
   logic        next_nmiPending;
   logic [4:0]  next_statusReg;
   logic [4:0]  next_irqEnable;
   logic [7:0]  next_regRdData;
   logic        next_takeInterrupt;
   logic [15:0] next_vectorAddr;
   viu_src_e    next_servedSource;
   logic        next_requestAcknowledgeOut;
   logic        next_irqOut;

   // Decoded helpers
   viu_src_e    pick;             // Winner at this boundary
   logic [4:0]  evtVec;           // Event pulses of this cycle
   logic        wrHit;            // Any register write

   // =======================================================
   // Maskable request lanes
   // Lane order follows the mask layout: bit 3 is the first
   // restart input, bit 0 the general request. A lane is armed
   // only while its mask bit and the master enable are both set.
   logic [3:0]  rawReq;           // Maskable levels by mask bit
   logic [3:0]  armedReq;         // Levels allowed to compete

   assign rawReq = {restartRequestFirst, restartRequestSecond,
                    restartRequestThird, generalRequest};

   for (genvar lane = 0; lane < 4; lane++)
   begin : g_lane
      // One gate per lane, mask bit and enable together
      assign armedReq[lane] = masterEnable && rawReq[lane] &&
                              maskReg[lane];           // [R9] [R10]
   end

   // =======================================================
   // Next-state logic
   // Priority, master enable, NMI latch, register port and the
   // registered answers are all resolved here in one pass
   always_comb
   begin
      // Defaults hold state; nmiPrev samples the NMI input
      next_maskReg      = maskReg;
      next_masterEnable = masterEnable;
      next_modeReg      = modeReg;
      next_statusReg    = statusReg;
      next_irqEnable    = irqEnable;
      next_nmiPrev      = nmiRequest;
      next_nmiPending   = nmiPending;
      pick              = SRC_NONE;
      evtVec            = 5'h00;
      wrHit             = regWrStb;

      // Priority resolution, NMI first. A latched NMI edge beats
      // every maskable lane and ignores mask and master enable.
      if (nmiPending)                                  // [R2] [R4]
         pick = SRC_NMI;
      // Maskable lanes in fixed order: first, second, third,
      // general; mask and enable are already folded into lanes
      else if (armedReq[`VIU_MASK_RST_A])              // [R4] [R10]
         pick = SRC_RST_A;
      else if (armedReq[`VIU_MASK_RST_B])              // [R4] [R10]
         pick = SRC_RST_B;
      else if (armedReq[`VIU_MASK_RST_C])              // [R4] [R10]
         pick = SRC_RST_C;
      else if (armedReq[`VIU_MASK_GENERAL])            // [R4] [R10]
         pick = SRC_GENERAL;

      // Only an instruction boundary accepts
      // Requests seen between boundaries stay pending at their
      // source; only the winner of a boundary is consumed
      if (!instrBoundary)                              // [R12]
         pick = SRC_NONE;

      // Master enable: acceptance clears, EI sets, DI clears
      // Acceptance wins over a same-cycle EI, so a handler always
      // starts with the maskable lanes locked out
      if (pick != SRC_NONE)
         next_masterEnable = 1'b0;
      else if (enableInterruptsInstruction)            // [R10]
         next_masterEnable = 1'b1;
      else if (disableInterruptsInstruction)
         next_masterEnable = 1'b0;

      // Mode load, illegal code 3 ignored
      // Dropping code 3 keeps the mode register always decodable
      if (modeLoad && modeValue <= `VIU_MODE_MAX)      // [R5]
         next_modeReg = modeValue;

      // Event pulses per source
      // One event bit per served source, feeding the sticky status
      unique case (pick)
         SRC_NMI:     evtVec[`VIU_EVT_NMI]     = 1'b1;
         SRC_RST_A:   evtVec[`VIU_EVT_RST_A]   = 1'b1;
         SRC_RST_B:   evtVec[`VIU_EVT_RST_B]   = 1'b1;
         SRC_RST_C:   evtVec[`VIU_EVT_RST_C]   = 1'b1;
         SRC_GENERAL: evtVec[`VIU_EVT_GENERAL] = 1'b1;
         SRC_NONE:    evtVec = 5'h00;
      endcase

      // NMI edge latch; a new edge wins over the serve clear
      // The latch keeps a short NMI pulse from being lost between
      // boundaries; a level held high is served only once
      if (pick == SRC_NMI)
         next_nmiPending = 1'b0;
      if (nmiRequest && !nmiPrev)                      // [R2]
         next_nmiPending = 1'b1;

      // Register writes
      // Unmapped offsets fall through and change nothing; they
      // belong to peripherals outside the unit
      if (wrHit)
      begin
         unique case (regAddr)
            `VIU_ADDR_MASK:                            // [R8] [R11]
               next_maskReg = regWrData[3:0];          // [R9]
            `VIU_ADDR_CLEAR:
               next_statusReg = statusReg & ~regWrData[4:0];
            `VIU_ADDR_ENABLE:
               next_irqEnable = regWrData[4:0];
            default:
               next_maskReg = maskReg;                 // Read-only or not ours
         endcase
      end

      // Sticky set wins over a same-cycle clear
      // so that an event is never lost to a late clear write
      next_statusReg = next_statusReg | evtVec;

      // Read data stands one cycle after the strobe only
      // The mask offset has no read branch and returns zero
      next_regRdData = 8'h00;
      if (regRdStb)
      begin
         unique case (regAddr)
            `VIU_ADDR_STATUS:
               next_regRdData = {3'h0, statusReg};
            `VIU_ADDR_ENABLE:
               next_regRdData = {3'h0, irqEnable};
            `VIU_ADDR_MODE:
               next_regRdData = {5'h00, masterEnable, modeReg};
            default:                                   // [R11]
               next_regRdData = 8'h00;
         endcase
      end

      // Sequencer answers
      // All but irqOut and generalMode stand for the cycle after the boundary only; the
      // acknowledge rises for the general request alone
      next_takeInterrupt         = (pick != SRC_NONE);
      next_servedSource          = pick;
      next_vectorAddr            = vecOf(pick, modeReg); // [R1] [R3]
      next_requestAcknowledgeOut = (pick == SRC_GENERAL); // [R7]
      next_irqOut = |(next_statusReg & next_irqEnable);
   end

   // =======================================================
   // Registers
   // Every output is a flop so the sequencer sees clean levels;
   // reset leaves all outputs idle and selects mode 0, and the
   // reset branch loads constants only
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         maskReg               <= 4'h0;
         masterEnable          <= 1'b0;
         modeReg               <= `VIU_RESET_MODE;     // [R6]
         nmiPrev               <= 1'b0;
         nmiPending            <= 1'b0;
         statusReg             <= 5'h00;
         irqEnable             <= 5'h00;
         regRdData             <= 8'h00;
         takeInterrupt         <= 1'b0;
         vectorAddr            <= 16'h0000;
         servedSource          <= SRC_NONE;
         generalMode           <= `VIU_RESET_MODE;     // [R6]
         requestAcknowledgeOut <= 1'b0;
         irqOut                <= 1'b0;
      end
      else
      begin
         maskReg               <= next_maskReg;
         masterEnable          <= next_masterEnable;
         modeReg               <= next_modeReg;
         nmiPrev               <= next_nmiPrev;
         nmiPending            <= next_nmiPending;
         statusReg             <= next_statusReg;
         irqEnable             <= next_irqEnable;
         regRdData             <= next_regRdData;
         takeInterrupt         <= next_takeInterrupt;
         vectorAddr            <= next_vectorAddr;
         servedSource          <= next_servedSource;
         generalMode           <= next_modeReg;
         requestAcknowledgeOut <= next_requestAcknowledgeOut;
         irqOut                <= next_irqOut;
      end
   end

endmodule

`default_nettype wire

//--- viu_core_properties.sv
// Purpose: Port checker of the interrupt unit.
// Assumes: Bound to viu_core below.
// Notes:   Top-level ports only.
`default_nettype none
module viu_core_props
(
   input wire logic               sys_clk,
   input wire logic               rst,
   input wire logic               instrBoundary,
   input wire logic               modeLoad,
   input wire viu_pkg::viu_mode_t modeValue,
   input wire logic [7:0]         regAddr,
   input wire logic               regRdStb,
   input wire logic [7:0]         regRdData,
   input wire logic               takeInterrupt,
   input wire logic [15:0]        vectorAddr,
   input wire viu_pkg::viu_src_e  servedSource,
   input wire viu_pkg::viu_mode_t generalMode,
   input wire logic               requestAcknowledgeOut
);
   import viu_pkg::*;
   default clocking dc @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   // ==========================================================
   // Port relations
   a_mask_unread:
      assert property (regRdStb && regAddr == 8'hbb |=> regRdData == 8'h00)
      else $error("mask read back");
   a_unused_read:
      assert property (regRdStb && regAddr == 8'h40 |=> regRdData == 8'h00)
      else $error("unused address read");
   a_take_boundary:
      assert property (takeInterrupt |-> $past(instrBoundary))
      else $error("take without boundary");
   a_nmi_vector:
      assert property (takeInterrupt && servedSource == SRC_NMI
         |-> vectorAddr == 16'h0066) else $error("nmi vector");
   a_restart_vector:
      assert property (servedSource inside {SRC_RST_A, SRC_RST_B, SRC_RST_C}
         |-> vectorAddr == 16'h003c - 16'(3'(servedSource) - 3'h2) * 16'h8)
      else $error("restart vector");
   a_ack_general:
      assert property (requestAcknowledgeOut ==
         (takeInterrupt && servedSource == SRC_GENERAL)) else $error("ack");
   a_mode_load:
      assert property (modeLoad && modeValue != 2'h3
         |=> generalMode == $past(modeValue)) else $error("mode load");
   a_mode_refuse:
      assert property (modeLoad && modeValue == 2'h3 |=> $stable(generalMode))
      else $error("mode 3 taken");
endmodule
bind viu_core viu_core_props i_props
(
   .sys_clk, .rst, .instrBoundary, .modeLoad, .modeValue, .regAddr,
   .regRdStb, .regRdData, .takeInterrupt, .vectorAddr, .servedSource,
   .generalMode, .requestAcknowledgeOut
);
`default_nettype wire

//--- viu_periph_model.sv
// Purpose: Peripherals holding request levels.
// Assumes: A level drops once its source is served.
// Notes:   Bit 0 NMI, 1 to 3 restarts, 4 general.
`default_nettype none
module viu_periph_model
(
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic [4:0]        raise,
   input  wire logic              takeInterrupt,
   input  wire viu_pkg::viu_src_e servedSource,
   output var  logic [4:0]        reqs
);
   import viu_pkg::*;
   logic [4:0] next_reqs; // Held levels
   // Raise on demand, drop once served
   always_comb
   begin
      next_reqs = reqs | raise;
      if (takeInterrupt && servedSource != SRC_NONE)
         next_reqs[3'(servedSource) - 3'h1] = 1'b0;
   end
   // Level register
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         reqs <= 5'h00;
      else
         reqs <= next_reqs;
endmodule
`default_nettype wire

//--- viu_core_tb.sv
// Purpose: Self-checking bench of the interrupt unit.
// Assumes: Answers come one cycle after the strobe.
// Notes:   No open waits.
`default_nettype none
module viu_core_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import viu_pkg::*;
   logic        sys_clk = 1'b0, rst = 1'b1, regWrStb = 1'b0;
   logic        regRdStb = 1'b0, modeLoad = 1'b0, instrBoundary = 1'b0;
   logic        enableInterruptsInstruction = 1'b0;
   logic        disableInterruptsInstruction = 1'b0;
   logic [7:0]  regAddr = 8'h00, regWrData = 8'h00, regRdData;
   logic [4:0]  raise = 5'h00, reqs;
   logic [15:0] vectorAddr;
   logic        takeInterrupt, requestAcknowledgeOut, irqOut;
   viu_mode_t   modeValue = 2'h0, generalMode;
   viu_src_e    servedSource;
   int          mismatches = 0, comparisons = 0;
   // ==========================================================
   // Design and peripherals
   viu_core i_dut
   (
      .sys_clk, .rst, .nmiRequest(reqs[0]), .restartRequestFirst(reqs[1]),
      .restartRequestSecond(reqs[2]), .restartRequestThird(reqs[3]),
      .generalRequest(reqs[4]), .instrBoundary, .modeLoad, .modeValue,
      .enableInterruptsInstruction, .disableInterruptsInstruction,
      .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
      .takeInterrupt, .vectorAddr, .servedSource, .generalMode,
      .requestAcknowledgeOut, .irqOut
   );
   viu_periph_model i_periph
   (
      .sys_clk, .rst, .raise, .takeInterrupt, .servedSource, .reqs
   );
   always #2.5 sys_clk = ~sys_clk;
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch %0t got %h want %h", $time, got, exp);
      end
   endtask
   // Register cycle; a read compares its data
   task automatic bus(input logic wr, input logic [7:0] a, d);
      @(posedge sys_clk);
      {regWrStb, regRdStb, regAddr, regWrData} <= {wr, !wr, a, d};
      @(posedge sys_clk);
      {regWrStb, regRdStb} <= 2'b00;
      #1;
      if (!wr)
         check(24'(regRdData), 24'(d));
   endtask
   // One-cycle sequencer strobes and raises
   task automatic go(input logic [2:0] s, input logic [4:0] r);
      @(posedge sys_clk);
      {modeLoad, enableInterruptsInstruction, instrBoundary, raise} <= {s, r};
      @(posedge sys_clk);
      {modeLoad, enableInterruptsInstruction, instrBoundary, raise} <= 8'h00;
      #1;
   endtask
   task automatic serve(input viu_src_e src, input logic [15:0] vec);
      go(3'b001, 5'h00);
      check({3'h0, takeInterrupt, requestAcknowledgeOut, 3'(servedSource),
         vectorAddr}, {3'h0, src != 0, src == SRC_GENERAL, 3'(src), vec});
   endtask
   task automatic irq_after(input logic e);
      @(posedge sys_clk);
      #1;
      check(24'(irqOut), 24'(e));
   endtask
   task automatic test_reset();
      check(24'(generalMode), 24'h0);
      bus(1'b0, 8'hb3, 8'h00);
      bus(1'b0, 8'hbb, 8'h00);
   endtask
   task automatic test_priority();
      logic [15:0] v [5] = '{16'h0066, 16'h003c, 16'h0034, 16'h002c, 16'h0};
      bus(1'b1, 8'hbb, 8'hff);
      go(3'b000, 5'h1f);
      for (int i = 0; i < 5; i++)
      begin
         go(3'b010, 5'h00);
         serve(viu_src_e'(i + 1), v[i]);
      end
   endtask
   task automatic test_mask();
      bus(1'b1, 8'hbb, 8'h07);
      go(3'b010, 5'h02);
      serve(SRC_NONE, 16'h0000);
      bus(1'b1, 8'hbb, 8'hf8);
      serve(SRC_RST_A, 16'h003c);
      bus(1'b1, 8'hbb, 8'h04);
      go(3'b000, 5'h04);
      serve(SRC_NONE, 16'h0000);
      go(3'b000, 5'h01);
      @(posedge sys_clk);
      serve(SRC_NMI, 16'h0066);
      go(3'b010, 5'h00);
      serve(SRC_RST_B, 16'h0034);
   endtask
   task automatic test_mode_irq();
      viu_mode_t m [3] = '{2'h2, 2'h3, 2'h1};
      bus(1'b1, 8'hb1, 8'h1f);
      bus(1'b1, 8'hb2, 8'h10);
      bus(1'b0, 8'hb2, 8'h10);
      for (int i = 0; i < 3; i++)
      begin
         @(posedge sys_clk);
         modeValue <= m[i];
         go(3'b100, 5'h00);
         check(24'(generalMode), 24'(i == 1 ? 2'h2 : m[i]));
      end
      bus(1'b1, 8'hbb, 8'h01);
      go(3'b010, 5'h10);
      serve(SRC_GENERAL, 16'h0038);
      bus(1'b0, 8'hb0, 8'h10);
      irq_after(1'b1);
      bus(1'b1, 8'hb2, 8'h00);
      irq_after(1'b0);
      bus(1'b1, 8'hb2, 8'h10);
      bus(1'b1, 8'hb1, 8'h10);
      irq_after(1'b0);
      bus(1'b1, 8'h40, 8'hff);
      bus(1'b0, 8'h40, 8'h00);
   endtask
   // Disable strobe drops the master enable; set beats clear
   task automatic test_disable();
      bus(1'b1, 8'hbb, 8'h08);
      go(3'b010, 5'h02);
      @(posedge sys_clk);
      disableInterruptsInstruction <= 1'b1;
      @(posedge sys_clk);
      disableInterruptsInstruction <= 1'b0;
      serve(SRC_NONE, 16'h0000);
      go(3'b010, 5'h00);
      @(posedge sys_clk);
      {regWrStb, regAddr, regWrData} <= {1'b1, 8'hb1, 8'h02};
      instrBoundary <= 1'b1;
      @(posedge sys_clk);
      {regWrStb, instrBoundary} <= 2'b00;
      #1;
      check({3'h0, takeInterrupt, requestAcknowledgeOut, 3'(servedSource),
         vectorAddr}, {3'h0, 2'b10, 3'(SRC_RST_A), 16'h003c});
      bus(1'b0, 8'hb0, 8'h02);
   endtask
   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      test_reset();
      test_priority();
      test_mask();
      test_mode_irq();
      test_disable();
      complete_run();
   end
endmodule
`default_nettype wire
